// ===== inc/lockup_guard_pkg.sv
// Purpose: Shared constants for the lockup guard timer block.
// Assumes: AXI4-Lite register access, 32-bit data, one word per register.
// Notes:   Offsets are byte addresses; reserved bits read as zero.

package lockup_guard_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] OFFSET_MODE    = 4'h0;
  localparam logic [3:0] OFFSET_COMMAND = 4'h4;
  localparam logic [3:0] OFFSET_STATUS  = 4'h8;

  typedef enum logic [1:0] {
    SEL_MODE,
    SEL_COMMAND,
    SEL_STATUS,
    SEL_NONE
  } reg_sel_t;

  // ----------------------------------------------------------------
  // Mode register fields
  // ----------------------------------------------------------------
  localparam int MODE_RUN_BIT      = 7;
  localparam int MODE_PERIOD_LSB   = 5;
  localparam int MODE_IDLE_RUN_BIT = 2;
  localparam int MODE_RESET_BIT    = 1;
  localparam logic [7:0] MODE_WRITE_MASK = 8'hE6;
  localparam logic [7:0] MODE_RESET_VALUE = 8'h80;

  // ----------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------
  localparam int STATUS_RUNNING_BIT  = 24;
  localparam int STATUS_BUS_HELD_BIT = 25;
  localparam int STATUS_RESET_BIT    = 26;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_CLEAR_COUNT = 8'h4E;
  localparam logic [7:0] CMD_DISABLE_KEY = 8'hB1;

  // ----------------------------------------------------------------
  // Counter and timing
  // ----------------------------------------------------------------
  localparam int COUNTER_STAGES = 22;
  localparam int TAP_BIT_DEFAULT [4] = '{15, 17, 19, 21};
  localparam int RESET_HOLD_STATES = 22;
  localparam logic [3:0] SYNC_RESET_VALUE = 4'b1000;

  // ----------------------------------------------------------------
  // Bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [31:0] READ_ZERO  = 32'h0000_0000;

endpackage

// ===== hw/guard_reset_stretch.sv
// Purpose: Stretches a timeout pulse into a fixed-length internal reset.
// Assumes: Single clock; trigger is a one-cycle pulse from the same domain.
// Notes:   A new trigger while active reloads the full length.

`timescale 1ns/100ps

module guard_reset_stretch
  import lockup_guard_pkg::*;
#(
  parameter int HOLD_STATES = RESET_HOLD_STATES
) (
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic trigger,
  output logic      resetActive
);

  localparam int CW = $clog2(HOLD_STATES + 1);
  localparam logic [CW-1:0] HOLD_COUNT = CW'(HOLD_STATES);

  logic [CW-1:0] remaining;

  // ----------------------------------------------------------------
  // Hold counter
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      remaining <= '0;
    end else if (trigger) begin
      remaining <= HOLD_COUNT;
    end else if (remaining != '0) begin
      remaining <= remaining - CW'(1);
    end
  end

  // Only the internal network is driven; no pin is touched
  assign resetActive = (remaining != '0);

endmodule

// ===== hw/lockup_guard_timer.sv
// Purpose: Watchdog counter with timeout interrupt and optional reset.
// Assumes: 50 MHz system clock; power-mode inputs arrive asynchronously.
// Notes:   Registers reached over AXI4-Lite; one write and one read at a time.
//
// The AXI4-Lite register port and the address map were decided locally.

`timescale 1ns/100ps

module lockup_guard_timer
  import lockup_guard_pkg::*;
#(
  parameter int ADDR_WIDTH  = 4,
  parameter int STAGES      = COUNTER_STAGES,
  parameter int TAP_BIT [4] = TAP_BIT_DEFAULT,
  parameter int HOLD_STATES = RESET_HOLD_STATES
) (
  input  wire logic                  clock,
  input  wire logic                  reset_n,
  input  wire logic [ADDR_WIDTH-1:0] awaddr,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  input  wire logic [ADDR_WIDTH-1:0] araddr,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready,
  input  wire logic                  deep_idle_mode,
  input  wire logic                  stopMode,
  input  wire logic                  light_idle_mode,
  input  wire logic                  bus_grant_ack_n,
  output logic                       guard_timeout_irq,
  output logic                       internalReset
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [ADDR_WIDTH-1:0] awAddrHeld;
  logic                  awHeld;
  logic [7:0]            wByteHeld;
  logic                  wLaneHeld;
  logic                  wHeld;
  logic                  doWrite;
  reg_sel_t              writeSel;
  reg_sel_t              readSel;

  logic [7:0]            guard_mode_reg;
  logic                  guardRunning;
  logic [STAGES-1:0]     counter;
  logic [3:0]            tapFull;
  logic                  counting;
  logic                  clearCount;
  logic                  timeoutHit;

  logic [3:0]            syncFirst;
  logic [3:0]            syncSecond;
  logic                  deepIdleSync;
  logic                  stopSync;
  logic                  lightIdleSync;
  logic                  busAckSync_n;

  logic [1:0]            timeout_period_sel;
  logic                  guard_run_bit;
  logic                  reset_on_timeout;
  logic                  light_idle_run_sel;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic reg_sel_t decodeReg(input logic [ADDR_WIDTH-1:0] addr);
    reg_sel_t sel;
    sel = SEL_NONE;
    if (addr == ADDR_WIDTH'(OFFSET_MODE)) begin
      sel = SEL_MODE;
    end else if (addr == ADDR_WIDTH'(OFFSET_COMMAND)) begin
      sel = SEL_COMMAND;
    end else if (addr == ADDR_WIDTH'(OFFSET_STATUS)) begin
      sel = SEL_STATUS;
    end
    return sel;
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Order: deep idle, stop, light idle, bus grant acknowledge
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      syncFirst  <= SYNC_RESET_VALUE;
      syncSecond <= SYNC_RESET_VALUE;
    end else begin
      syncFirst  <= {bus_grant_ack_n, light_idle_mode, stopMode, deep_idle_mode};
      syncSecond <= syncFirst;
    end
  end

  assign deepIdleSync  = syncSecond[0];
  assign stopSync      = syncSecond[1];
  assign lightIdleSync = syncSecond[2];
  assign busAckSync_n  = syncSecond[3];

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  // Address and data are parked independently, so either may come first
  assign awready  = !awHeld;
  assign wready   = !wHeld;
  assign doWrite  = awHeld && wHeld && !bvalid;
  assign writeSel = decodeReg(awAddrHeld);

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      awHeld     <= 1'b0;
      awAddrHeld <= '0;
    end else if (awvalid && awready) begin
      awHeld     <= 1'b1;
      awAddrHeld <= awaddr;
    end else if (doWrite) begin
      awHeld     <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      wHeld     <= 1'b0;
      wByteHeld <= 8'h00;
      wLaneHeld <= 1'b0;
    end else if (wvalid && wready) begin
      wHeld     <= 1'b1;
      wByteHeld <= wdata[7:0];
      wLaneHeld <= wstrb[0];
    end else if (doWrite) begin
      wHeld     <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (doWrite) begin
      bvalid <= 1'b1;
      bresp  <= (writeSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  assign arready = !rvalid;
  assign readSel = decodeReg(araddr);

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rvalid <= 1'b0;
      rresp  <= RESP_OKAY;
      rdata  <= READ_ZERO;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp  <= (readSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      unique case (readSel)
        SEL_MODE: begin
          rdata <= {24'h00_0000, guard_mode_reg};
        end
        SEL_STATUS: begin
          rdata <= READ_ZERO;
          rdata[STAGES-1:0]          <= counter;
          rdata[STATUS_RUNNING_BIT]  <= guardRunning;
          rdata[STATUS_BUS_HELD_BIT] <= !busAckSync_n;
          rdata[STATUS_RESET_BIT]    <= internalReset;
        end
        // Command register is write-only and reads as zero
        SEL_COMMAND, SEL_NONE: begin
          rdata <= READ_ZERO;
        end
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Mode register
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      guard_mode_reg <= MODE_RESET_VALUE;
    end else if (doWrite && writeSel == SEL_MODE && wLaneHeld) begin
      guard_mode_reg <= wByteHeld & MODE_WRITE_MASK;
    end
  end

  assign timeout_period_sel = guard_mode_reg[MODE_PERIOD_LSB +: 2];
  assign guard_run_bit      = guard_mode_reg[MODE_RUN_BIT];
  assign reset_on_timeout   = guard_mode_reg[MODE_RESET_BIT];
  assign light_idle_run_sel = guard_mode_reg[MODE_IDLE_RUN_BIT];

  // ----------------------------------------------------------------
  // Run state
  // ----------------------------------------------------------------
  // The key alone cannot stop a lost program: the run bit must be low first
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      guardRunning <= 1'b1;
    end else if (doWrite && wLaneHeld) begin
      if (writeSel == SEL_MODE && wByteHeld[MODE_RUN_BIT]) begin
        guardRunning <= 1'b1;
      end else if (writeSel == SEL_COMMAND && wByteHeld == CMD_DISABLE_KEY
                   && !guard_run_bit) begin
        guardRunning <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // Bus grant is deliberately absent here: counting goes on meanwhile
  assign counting = guardRunning && !deepIdleSync && !stopSync
                    && !(lightIdleSync && !light_idle_run_sel);

  // Any command value other than the clear code leaves the count alone
  assign clearCount = (doWrite && wLaneHeld && writeSel == SEL_COMMAND
                       && wByteHeld == CMD_CLEAR_COUNT)
                      || deepIdleSync || stopSync;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      counter <= '0;
    end else if (clearCount) begin
      counter <= '0;
    end else if (counting) begin
      counter <= counter + STAGES'(1);
    end
  end

  // ----------------------------------------------------------------
  // Tap selection
  // ----------------------------------------------------------------
  // A tap overflows when every bit below it is set and one more cycle counts
  for (genvar g = 0; g < 4; g++) begin : gTap
    assign tapFull[g] = &counter[TAP_BIT[g]-1:0];
  end

  assign timeoutHit = counting && !clearCount
                      && tapFull[timeout_period_sel];

  // ----------------------------------------------------------------
  // Timeout outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      guard_timeout_irq <= 1'b0;
    end else begin
      guard_timeout_irq <= timeoutHit;
    end
  end

  guard_reset_stretch #(
    .HOLD_STATES (HOLD_STATES)
  ) resetStretch (
    .clock       (clock),
    .reset_n     (reset_n),
    .trigger     (timeoutHit && reset_on_timeout),
    .resetActive (internalReset)
  );

endmodule

// ===== tb/core_model.sv
// Purpose: Core-side model that tallies timeout interrupts and resets.
// Assumes: Interrupt is a one-cycle pulse; the internal reset is a level.
// Notes:   Reset length is taken when the reset drops, in clock states.
`timescale 1ns/100ps
module core_model (
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic irq,
  input  wire logic sysReset,
  output int        irqCount,
  output int        resetCount,
  output int        resetLen
);
  int run;

  // ----------------------------------------
  // Event tally
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      irqCount   <= 0;
      resetCount <= 0;
      resetLen   <= 0;
      run        <= 0;
    end else begin
      if (irq) begin
        irqCount <= irqCount + 1;
      end
      if (sysReset) begin
        run <= run + 1;
      end else if (run != 0) begin
        resetLen   <= run;
        resetCount <= resetCount + 1;
        run        <= 0;
      end
    end
  end
endmodule

// ===== tb/lockup_guard_checker.sv
// Purpose: Port-level timing checks for the lockup guard timer.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Smallest tap is taken to be at least 3 counter bits.
`timescale 1ns/100ps
module lockup_guard_checker
  import lockup_guard_pkg::*;
#(
  parameter int HOLD_STATES = RESET_HOLD_STATES
) (
  input wire logic       clock,
  input wire logic       reset_n,
  input wire logic       awvalid,
  input wire logic       awready,
  input wire logic       wvalid,
  input wire logic       wready,
  input wire logic [1:0] bresp,
  input wire logic       bvalid,
  input wire logic       arvalid,
  input wire logic       arready,
  input wire logic       rvalid,
  input wire logic       deep_idle_mode,
  input wire logic       stopMode,
  input wire logic       guard_timeout_irq,
  input wire logic       internalReset
);
  int holdCount;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  // ----------------------------------------
  // Reset length helper
  // ----------------------------------------
  // Restarts on every timeout, since a retrigger reloads the full span
  always_ff @(posedge clock) begin
    if (guard_timeout_irq) begin
      holdCount <= 1;
    end else if (internalReset) begin
      holdCount <= holdCount + 1;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_irq_single_pulse: assert property (guard_timeout_irq |=> (!guard_timeout_irq)[*7])
    else $error("timeout interrupt not a lone pulse");
  a_reset_on_timeout: assert property ($rose(internalReset) |-> guard_timeout_irq)
    else $error("internal reset without timeout");
  a_reset_first_span: assert property ($rose(internalReset) |=> internalReset[*8])
    else $error("internal reset dropped early");
  a_reset_span_exact: assert property ($fell(internalReset) |-> holdCount == HOLD_STATES)
    else $error("internal reset length wrong");
  a_idle_no_irq: assert property ((deep_idle_mode || stopMode)[*4] |-> !guard_timeout_irq)
    else $error("timeout while counter halted");
  a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write response missing");
  a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read response missing");
  // Only the rising edge: a held response may overlap a newly parked request
  a_ready_after_resp: assert property ($rose(bvalid) |-> awready && wready)
    else $error("write channels not free at response");

  c_timeout: cover property (guard_timeout_irq);
  c_reset_done: cover property ($fell(internalReset));
  c_unmapped: cover property (bvalid && bresp == RESP_SLVERR);
endmodule

bind lockup_guard_timer lockup_guard_checker #(.HOLD_STATES(HOLD_STATES)) u_checker (
  .clock(clock), .reset_n(reset_n), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
  .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
  .deep_idle_mode(deep_idle_mode), .stopMode(stopMode),
  .guard_timeout_irq(guard_timeout_irq), .internalReset(internalReset));

// ===== tb/lockup_guard_timer_tb_top.sv
// Purpose: Self-checking bench for the lockup guard timer.
// Assumes: Short taps so every period fits in a short run.
// Notes:   bready and rready stay high; wstrb enables byte 0 only.
`timescale 1ns/100ps
module lockup_guard_timer_tb_top
  import lockup_guard_pkg::*;
;
  localparam int TAPS [4] = '{3, 4, 5, 6};
  typedef struct {logic [7:0] mode; int cycles;} row_t;

  logic        clock, reset_n, awvalid, wvalid, arvalid, deepIdle, stopIn, lightIdle;
  logic        busAck, awready, wready, bvalid, arready, rvalid, irq, sysReset;
  logic [3:0]  awaddr, araddr;
  logic [1:0]  bresp, rresp, rsp;
  logic [31:0] wdata, rdata, rd;
  int          miscompares, samples_checked, n, c, irqCount, resetCount, resetLen;
  row_t        rows [4];

  lockup_guard_timer #(.TAP_BIT(TAPS), .HOLD_STATES(RESET_HOLD_STATES)) u_lockup_guard_timer (
    .clock(clock), .reset_n(reset_n), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'h1), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(1'b1), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(1'b1),
    .deep_idle_mode(deepIdle), .stopMode(stopIn), .light_idle_mode(lightIdle),
    .bus_grant_ack_n(busAck), .guard_timeout_irq(irq), .internalReset(sysReset));

  core_model u_core_model (
    .clock(clock), .reset_n(reset_n), .irq(irq), .sysReset(sysReset),
    .irqCount(irqCount), .resetCount(resetCount), .resetLen(resetLen));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task stop_test;
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task wr(input logic [3:0] a, input logic [7:0] d);
    awaddr  <= a;
    wdata   <= 32'(d);
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rsp = bresp;
  endtask

  task rdreg(input logic [3:0] a);
    araddr  <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd  = rdata;
    rsp = rresp;
  endtask

  task cyc(input int k);
    repeat (k) @(posedge clock);
  endtask

  // Edges from now until the interrupt is seen high
  task untilIrq;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (irq !== 1'b1 && n < 5000);
  endtask

  // The new mode is only written from the stopped state
  task setMode(input logic [7:0] m);
    wr(OFFSET_MODE, 8'h00);
    wr(OFFSET_COMMAND, CMD_CLEAR_COUNT);
    wr(OFFSET_COMMAND, CMD_DISABLE_KEY);
    wr(OFFSET_MODE, m);
  endtask

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  initial begin
    repeat (30000) @(posedge clock);
    miscompares++;
    stop_test;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rows = '{'{8'h80, 1 << TAPS[0]}, '{8'hA0, 1 << TAPS[1]},
             '{8'hC0, 1 << TAPS[2]}, '{8'hE0, 1 << TAPS[3]}};
    {reset_n, awvalid, wvalid, arvalid, deepIdle, stopIn, lightIdle} = '0;
    busAck = 1'b1;
    awaddr = '0;
    araddr = '0;
    wdata  = '0;
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    untilIrq;
    check(32'(n), 32'((1 << TAPS[0]) + 1));
    rdreg(OFFSET_MODE);
    check(rd, 32'(MODE_RESET_VALUE));
    check(32'(resetCount), 32'h0000_0000);
    foreach (rows[i]) begin
      setMode(rows[i].mode);
      rdreg(OFFSET_MODE);
      check(rd, 32'(rows[i].mode));
      wr(OFFSET_COMMAND, CMD_CLEAR_COUNT);
      untilIrq;
      check(32'(n), 32'(rows[i].cycles));
    end
    for (int k = 0; k < 2; k++) begin
      deepIdle <= (k == 0);
      stopIn   <= (k == 1);
      cyc(4);
      c = irqCount;
      cyc(100);
      rdreg(OFFSET_STATUS);
      check(32'(rd[21:0]), 32'h0000_0000);
      check(32'(irqCount), 32'(c));
    end
    stopIn    <= 1'b0;
    lightIdle <= 1'b1;
    busAck    <= 1'b0;
    cyc(4);
    c = irqCount;
    cyc(100);
    check(32'(irqCount), 32'(c));
    rdreg(OFFSET_STATUS);
    check(32'(rd[STATUS_BUS_HELD_BIT]), 32'h0000_0001);
    setMode(8'hE4);
    wr(OFFSET_COMMAND, CMD_CLEAR_COUNT);
    untilIrq;
    check(32'(n), 32'(1 << TAPS[3]));
    lightIdle <= 1'b0;
    busAck    <= 1'b1;
    // One write after the clear costs three edges of the period
    for (int k = 0; k < 2; k++) begin
      wr(OFFSET_COMMAND, CMD_CLEAR_COUNT);
      wr(OFFSET_COMMAND, k ? 8'h55 : CMD_DISABLE_KEY);
      untilIrq;
      check(32'(n), 32'((1 << TAPS[3]) - 3));
    end
    setMode(8'h00);
    c = irqCount;
    wr(OFFSET_COMMAND, CMD_CLEAR_COUNT);
    cyc(100);
    check(32'(irqCount), 32'(c));
    rdreg(OFFSET_STATUS);
    check(32'(rd[STATUS_RUNNING_BIT]), 32'h0000_0000);
    wr(OFFSET_MODE, 8'hE6);
    wr(OFFSET_COMMAND, CMD_CLEAR_COUNT);
    untilIrq;
    check(32'(n), 32'(1 << TAPS[3]));
    rdreg(OFFSET_STATUS);
    check(32'(rd[STATUS_RESET_BIT]), 32'h0000_0001);
    cyc(30);
    check(32'(resetLen), 32'(RESET_HOLD_STATES));
    check(32'(resetCount), 32'h0000_0001);
    wr(4'hC, 8'h80);
    check(32'(rsp), 32'(RESP_SLVERR));
    rdreg(OFFSET_MODE);
    check(rd, 32'h0000_00E6);
    check(32'(rsp), 32'(RESP_OKAY));
    rdreg(4'hC);
    check(32'(rsp), 32'(RESP_SLVERR));
    check(rd, 32'h0000_0000);
    stop_test;
  end
endmodule
